// ==== src/sfm_fault_latch.sv ====
`timescale 1ns/1ps
module sfm_fault_latch (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic q_o
);
	// Set beats clear so a fresh event is never lost
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_o <= 1'b0;
		end else if (set_i) begin
			q_o <= 1'b1;
		end else if (clr_i) begin
			q_o <= 1'b0;
		end
	end

	chk_latch_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(q_o && !clr_i) |=> q_o) else $error("fault dropped without clear");
	chk_latch_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		set_i |=> q_o) else $error("fault not latched");
endmodule

// ==== src/sfm_fault_manager.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Only the highest-priority active fault is displayed, flash checksum first.
// - Any active fault replaces the operating status on the display.
// - Travel limit faults clear themselves once the limit input drops.
// - Resettable faults clear on reset button or reset input once condition gone.
// - Encoder faults reset by button on programmable variant, else power cycle only.
// - Self-test failure latches; reset ignored, only power cycle clears it.
// - Motor position keeps counting whatever faults are active.
// - Bus overvoltage fault when bus voltage exceeds the upper threshold.
// - Bus undervoltage fault when bus voltage drops below the lower threshold.
// - Undervoltage must persist for the whole debounce interval before raising.
// - A monitor enable setting suppresses the undervoltage fault when cleared.
// - Prototype: undervoltage auto-clears at recovery level and cannot be disabled.
// - Prototype: undervoltage also raised on a fixed drop below soft-start level.
// - Firmware checksum fault clears only on reprogramming.
// - Memory integrity checked at power-up; bad contents raise memory fault.
// - Board identity mismatch raises the invalid configuration fault.
// - Power stage overtemp, overcurrent or supply loss raise power module fault.
// - Drive overtemp clears on cooling; motor overtemp also needs a reset.
module sfm_fault_manager
	import sfm_pkg::*;
#(
	parameter int DEBOUNCE_CYC = LOW_DEBOUNCE_CYC
) (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic [BUS_W-1:0] BUS_VOLTS_I,
	input wire logic LOW_BUS_MON_EN_I,
	input wire logic PROTOTYPE_I,
	input wire logic PROGRAMMABLE_I,
	input wire logic SOFTSTART_DONE_I,
	input wire logic SELFTEST_FAIL_I,
	input wire logic FW_CSUM_FAIL_I,
	input wire logic FW_REPROG_I,
	input wire logic NVM_CHECK_DONE_I,
	input wire logic NVM_BAD_I,
	input wire logic [ID_W-1:0] BOARD_ID_I,
	input wire logic [ID_W-1:0] POWER_ID_I,
	input wire logic PS_OVERTEMP_I,
	input wire logic PS_OVERCURRENT_I,
	input wire logic PS_SUPPLY_LOST_I,
	input wire logic DRIVE_HOT_I,
	input wire logic MOTOR_HOT_I,
	input wire logic ENC_STATE_ERR_I,
	input wire logic ENC_HW_ERR_I,
	input wire logic SHUNT_OVER_I,
	input wire logic OVERSPEED_I,
	input wire logic FOLLOW_ERR_I,
	input wire logic LIMIT_POS_I,
	input wire logic LIMIT_NEG_I,
	input wire logic SYNC_ERR_I,
	input wire logic RUNTIME_ERR_I,
	input wire logic RESET_BUTTON_I,
	input wire logic RESET_INPUT_I,
	input wire logic ENC_A_I,
	input wire logic ENC_B_I,
	input wire logic [4:0] STATUS_CODE_I,
	output logic [4:0] DISPLAY_O,
	output logic FAULT_SHOWN_O,
	output logic BRIDGE_EN_O,
	output logic [NF-1:0] ACTIVE_FAULTS_O,
	output logic [POS_W-1:0] POSITION_O
);
	logic [NF-1:0] act;
	logic [NF-1:0] cond;
	logic [NF-1:0] set_v;
	logic [NF-1:0] clr_v;
	logic reset_req;
	logic under_raw;
	logic low_set;
	logic low_mon_en;
	logic bus_drop;
	logic [DEB_W-1:0] low_cnt_q;
	logic [BUS_W-1:0] ss_level_q;
	logic ss_valid_q;
	logic a_q;
	logic b_q;
	logic enc_primed_q;
	logic [4:0] code_d;
	logic [4:0] display_d;
	logic [POS_W-1:0] pos_d;

	assign reset_req = RESET_BUTTON_I | RESET_INPUT_I;
	assign low_mon_en = LOW_BUS_MON_EN_I | PROTOTYPE_I;

	// Drop test guards the subtraction against wrap on a low soft-start level
	assign bus_drop = PROTOTYPE_I && ss_valid_q && (ss_level_q >= BUS_DROP_V) &&
		(BUS_VOLTS_I < ss_level_q - BUS_DROP_V);
	assign under_raw = (BUS_VOLTS_I < BUS_LOW_V) || bus_drop;
	assign low_set = under_raw && (low_cnt_q == DEB_W'(DEBOUNCE_CYC - 1));

	// Soft-start bus level, reloaded on each soft-start done, held until logic power goes
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ss_level_q <= '0;
			ss_valid_q <= 1'b0;
		end else if (SOFTSTART_DONE_I) begin
			ss_level_q <= BUS_VOLTS_I;
			ss_valid_q <= 1'b1;
		end
	end

	// Counter saturates so a long sag keeps the set term asserted
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			low_cnt_q <= '0;
		end else if (!under_raw) begin
			low_cnt_q <= '0;
		end else if (low_cnt_q != DEB_W'(DEBOUNCE_CYC - 1)) begin
			low_cnt_q <= low_cnt_q + 1'b1;
		end
	end

	// Raw conditions per fault
	always_comb begin
		cond = '0;
		cond[F_FLASH] = FW_CSUM_FAIL_I;
		cond[F_SELFTEST] = SELFTEST_FAIL_I;
		cond[F_NVM] = NVM_BAD_I;
		cond[F_CONFIG] = BOARD_ID_I != POWER_ID_I;
		cond[F_DRV_HOT] = DRIVE_HOT_I;
		cond[F_PWR_MOD] = PS_OVERTEMP_I | PS_OVERCURRENT_I | PS_SUPPLY_LOST_I;
		cond[F_BUS_HIGH] = BUS_VOLTS_I > BUS_HIGH_V;
		cond[F_BUS_LOW] = under_raw;
		cond[F_ENC_STATE] = ENC_STATE_ERR_I;
		cond[F_ENC_HW] = ENC_HW_ERR_I;
		cond[F_MOT_HOT] = MOTOR_HOT_I;
		cond[F_SHUNT] = SHUNT_OVER_I;
		cond[F_OVERSPEED] = OVERSPEED_I;
		cond[F_FOLLOW] = FOLLOW_ERR_I;
		cond[F_LIMIT_POS] = LIMIT_POS_I;
		cond[F_LIMIT_NEG] = LIMIT_NEG_I;
		cond[F_SYNC] = SYNC_ERR_I;
		cond[F_RUNTIME] = RUNTIME_ERR_I;
	end

	// Set terms; memory check only counts on its completion strobe
	always_comb begin
		set_v = cond;
		set_v[F_NVM] = NVM_CHECK_DONE_I & NVM_BAD_I;
		set_v[F_BUS_LOW] = low_set & low_mon_en;
	end

	// Clearing policy per fault
	always_comb begin
		clr_v = reset_req ? ~cond : '0;
		clr_v[F_FLASH] = FW_REPROG_I & ~cond[F_FLASH];
		clr_v[F_SELFTEST] = 1'b0;
		clr_v[F_DRV_HOT] = ~cond[F_DRV_HOT];
		clr_v[F_MOT_HOT] = reset_req & ~cond[F_MOT_HOT];
		if (PROTOTYPE_I) begin
			clr_v[F_BUS_LOW] = BUS_VOLTS_I >= BUS_RECOVER_V;
		end
		if (!PROGRAMMABLE_I) begin
			clr_v[F_ENC_STATE] = 1'b0;
			clr_v[F_ENC_HW] = 1'b0;
		end
		clr_v[F_LIMIT_POS] = ~cond[F_LIMIT_POS];
		clr_v[F_LIMIT_NEG] = ~cond[F_LIMIT_NEG];
		clr_v[F_SYNC] = 1'b0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++) begin : g_fault
			sfm_fault_latch u_latch (
				.clk_i(CLK_I),
				.arst_n_i(ARST_N_I),
				.set_i(set_v[gi]),
				.clr_i(clr_v[gi]),
				.q_o(act[gi])
			);
		end
	endgenerate

	// Lowest index wins; scan downward so it is assigned last
	always_comb begin
		code_d = CODE_NONE;
		for (int i = NF - 1; i >= 0; i--) begin
			if (act[i]) begin
				code_d = 5'(i) + CODE_BASE;
			end
		end
		display_d = (|act) ? code_d : STATUS_CODE_I;
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DISPLAY_O <= CODE_NONE;
			FAULT_SHOWN_O <= 1'b0;
		end else begin
			DISPLAY_O <= display_d;
			FAULT_SHOWN_O <= |act;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			BRIDGE_EN_O <= 1'b0;
		end else begin
			BRIDGE_EN_O <= ~|(act & ~BRIDGE_KEEP_MASK);
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ACTIVE_FAULTS_O <= '0;
		end else begin
			ACTIVE_FAULTS_O <= act;
		end
	end

	// Quadrature decode; no fault term reaches it so tracking never stops
	always_comb begin
		pos_d = POSITION_O;
		if (enc_primed_q && ((ENC_A_I ^ a_q) ^ (ENC_B_I ^ b_q))) begin
			if (a_q ^ ENC_B_I) begin
				pos_d = POSITION_O + 1'b1;
			end else begin
				pos_d = POSITION_O - 1'b1;
			end
		end
	end

	// A double step is an illegal jump and is not counted
	// First edge after reset only loads pin history, so no false step
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			enc_primed_q <= 1'b0;
			POSITION_O <= POS_RESET;
		end else begin
			a_q <= ENC_A_I;
			b_q <= ENC_B_I;
			enc_primed_q <= 1'b1;
			POSITION_O <= pos_d;
		end
	end

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	chk_display_priority: assert property (
		(act[F_FLASH] && act[F_SELFTEST]) |=> DISPLAY_O == CODE_BASE)
		else $error("lower priority fault displayed");
	chk_fault_overrides: assert property (
		(|act) |=> FAULT_SHOWN_O && DISPLAY_O != CODE_NONE)
		else $error("status shown during fault");
	chk_status_when_clear: assert property (
		!(|act) |=> !FAULT_SHOWN_O && DISPLAY_O == $past(STATUS_CODE_I))
		else $error("status not shown without fault");
	chk_limit_autoclear: assert property (
		(act[F_LIMIT_POS] && !LIMIT_POS_I) |=> !act[F_LIMIT_POS])
		else $error("travel limit fault not auto-cleared");
	chk_needs_reset: assert property (
		(act[F_BUS_HIGH] && !reset_req) |=> act[F_BUS_HIGH])
		else $error("overvoltage fault cleared without reset");
	chk_encoder_sticky: assert property (
		(act[F_ENC_HW] && !PROGRAMMABLE_I) |=> act[F_ENC_HW])
		else $error("encoder fault cleared on fixed variant");
	chk_selftest_sticky: assert property (
		act[F_SELFTEST] |=> act[F_SELFTEST] [*8])
		else $error("self-test fault cleared");
	chk_pos_tracks: assert property (
		(enc_primed_q && ENC_A_I != a_q && ENC_B_I == b_q) |=> POSITION_O != $past(POSITION_O))
		else $error("position not updated");
	chk_bus_high_set: assert property (
		(BUS_VOLTS_I > BUS_HIGH_V) |=> act[F_BUS_HIGH] ##1 !BRIDGE_EN_O)
		else $error("overvoltage not raised");
	chk_low_debounce: assert property (
		$rose(act[F_BUS_LOW]) |-> $past(low_cnt_q) == DEB_W'(DEBOUNCE_CYC - 1))
		else $error("undervoltage raised before debounce");
	chk_low_disabled: assert property (
		(!low_mon_en && !act[F_BUS_LOW]) |=> !act[F_BUS_LOW])
		else $error("undervoltage raised while disabled");
	chk_bridge_off: assert property (
		act[F_PWR_MOD] |=> !BRIDGE_EN_O)
		else $error("bridge enabled during fault");
	chk_bridge_limit: assert property (
		(act == (act & BRIDGE_KEEP_MASK)) |=> BRIDGE_EN_O)
		else $error("bridge disabled by travel limit");
	chk_bridge_low_bus: assert property (
		act[F_BUS_LOW] |=> !BRIDGE_EN_O)
		else $error("bridge enabled during undervoltage");

	// Clearing policy per fault class
	chk_limit_neg_clear: assert property (
		(act[F_LIMIT_NEG] && !LIMIT_NEG_I) |=> !act[F_LIMIT_NEG])
		else $error("negative limit fault not auto-cleared");
	chk_config_reset: assert property (
		(act[F_CONFIG] && reset_req && BOARD_ID_I == POWER_ID_I) |=> !act[F_CONFIG])
		else $error("configuration fault kept after reset");
	chk_shunt_reset: assert property (
		(act[F_SHUNT] && reset_req && !SHUNT_OVER_I) |=> !act[F_SHUNT])
		else $error("shunt fault kept after reset");
	chk_encoder_reset: assert property (
		(act[F_ENC_STATE] && PROGRAMMABLE_I && reset_req && !ENC_STATE_ERR_I) |=>
		!act[F_ENC_STATE])
		else $error("encoder fault kept after reset on programmable variant");
	chk_flash_sticky: assert property (
		(act[F_FLASH] && !FW_REPROG_I) |=> act[F_FLASH])
		else $error("flash fault cleared without reprogramming");
	chk_drive_cooled: assert property (
		(act[F_DRV_HOT] && !DRIVE_HOT_I) |=> !act[F_DRV_HOT])
		else $error("drive overtemp kept after cooling");
	chk_motor_reset: assert property (
		(act[F_MOT_HOT] && !reset_req) |=> act[F_MOT_HOT])
		else $error("motor overtemp cleared without reset");

	// Raise terms of identity, memory and power stage faults
	chk_nvm_set: assert property (
		(NVM_CHECK_DONE_I && NVM_BAD_I) |=> act[F_NVM])
		else $error("memory fault not raised");
	chk_config_set: assert property (
		(BOARD_ID_I != POWER_ID_I) |=> act[F_CONFIG])
		else $error("configuration fault not raised");
	chk_power_module: assert property (
		(PS_OVERTEMP_I || PS_OVERCURRENT_I || PS_SUPPLY_LOST_I) |=> act[F_PWR_MOD])
		else $error("power module fault not raised");

	// Undervoltage threshold and prototype policy
	chk_low_threshold: assert property (
		(low_mon_en && BUS_VOLTS_I < BUS_LOW_V && low_cnt_q == DEB_W'(DEBOUNCE_CYC - 1))
		|=> act[F_BUS_LOW])
		else $error("undervoltage not raised after debounce");
	chk_proto_hold: assert property (
		(PROTOTYPE_I && act[F_BUS_LOW] && BUS_VOLTS_I < BUS_RECOVER_V) |=> act[F_BUS_LOW])
		else $error("prototype undervoltage cleared below recovery");
	chk_proto_recover: assert property (
		(PROTOTYPE_I && act[F_BUS_LOW] && BUS_VOLTS_I >= BUS_RECOVER_V && !set_v[F_BUS_LOW])
		|=> !act[F_BUS_LOW])
		else $error("prototype undervoltage not auto-cleared");
	chk_proto_drop: assert property (
		bus_drop |=> low_cnt_q != '0)
		else $error("soft-start drop not debounced");

	cov_low_bus: cover property ($rose(act[F_BUS_LOW]));
	cov_reset_clear: cover property (act[F_BUS_HIGH] ##1 !act[F_BUS_HIGH]);
	cov_two_faults: cover property (act[F_PWR_MOD] && act[F_LIMIT_NEG]);
	cov_limit_run: cover property (act[F_LIMIT_POS] && BRIDGE_EN_O);
	cov_proto_drop: cover property (bus_drop && act[F_BUS_LOW]);
endmodule

// ==== src/sfm_pkg.sv ====
package sfm_pkg;
	// Fault indices, highest display priority first
	localparam int NF = 18;
	localparam int F_FLASH = 0;
	localparam int F_SELFTEST = 1;
	localparam int F_NVM = 2;
	localparam int F_CONFIG = 3;
	localparam int F_DRV_HOT = 4;
	localparam int F_PWR_MOD = 5;
	localparam int F_BUS_HIGH = 6;
	localparam int F_BUS_LOW = 7;
	localparam int F_ENC_STATE = 8;
	localparam int F_ENC_HW = 9;
	localparam int F_MOT_HOT = 10;
	localparam int F_SHUNT = 11;
	localparam int F_OVERSPEED = 12;
	localparam int F_FOLLOW = 13;
	localparam int F_LIMIT_POS = 14;
	localparam int F_LIMIT_NEG = 15;
	localparam int F_SYNC = 16;
	localparam int F_RUNTIME = 17;
	// Display code of fault i is i + CODE_BASE; zero means no fault
	localparam logic [4:0] CODE_NONE = 5'h00;
	localparam logic [4:0] CODE_BASE = 5'h01;
	// Faults that leave the power bridge enabled
	localparam logic [NF-1:0] BRIDGE_KEEP_MASK = 18'h0C000;
	// Bus voltage thresholds in volts
	localparam int BUS_W = 10;
	localparam logic [BUS_W-1:0] BUS_HIGH_V = 10'h19F;
	localparam logic [BUS_W-1:0] BUS_LOW_V = 10'h03C;
	localparam logic [BUS_W-1:0] BUS_RECOVER_V = 10'h08C;
	localparam logic [BUS_W-1:0] BUS_DROP_V = 10'h032;
	// Timing
	localparam int CLK_KHZ = 200000;
	localparam int LOW_DEBOUNCE_MS = 50;
	localparam int LOW_DEBOUNCE_CYC = LOW_DEBOUNCE_MS * CLK_KHZ;
	localparam int DEB_W = 24;
	localparam int POS_W = 32;
	localparam logic [POS_W-1:0] POS_RESET = 32'h00000000;
	localparam int ID_W = 8;
endpackage

// ==== tb/sfm_fault_manager_bench.sv ====
`timescale 1ns/1ps
module sfm_fault_manager_bench;
	import sfm_pkg::*;
	localparam int DEB = 20;
	logic clk = 1'b0, arst_n = 1'b0, mon_en = 1'b1, proto = 1'b0, progr = 1'b0, ss = 1'b0;
	logic st_fail = 1'b0, csum = 1'b0, reprog = 1'b0, nvm_done = 1'b0, nvm_bad = 1'b0;
	logic pt = 1'b0, pc = 1'b0, pl = 1'b0, dhot = 1'b0, mhot = 1'b0, enc_st = 1'b0;
	logic enc_hw = 1'b0, shunt = 1'b0, ospd = 1'b0, fol = 1'b0, lp = 1'b0, ln = 1'b0;
	logic sync = 1'b0, rt = 1'b0, rbtn = 1'b0, rin = 1'b0, step = 1'b0, dir = 1'b1;
	logic enc_a, enc_b, shown, bren;
	logic [BUS_W-1:0] bus = 10'h12C;
	logic [ID_W-1:0] bid = 8'h5A, pid = 8'h5A;
	logic [4:0] status = 5'h0B;
	logic [4:0] disp;
	logic [NF-1:0] act;
	logic [POS_W-1:0] pos;
	int n_errors = 0;
	int cmp_count = 0;
	always #2.5 clk = ~clk;
	sfm_plant_model PLANT (.clk_i(clk), .step_i(step), .dir_i(dir), .enc_a_o(enc_a),
		.enc_b_o(enc_b));
	sfm_fault_manager #(.DEBOUNCE_CYC(DEB)) DUT (.CLK_I(clk), .ARST_N_I(arst_n),
		.BUS_VOLTS_I(bus), .LOW_BUS_MON_EN_I(mon_en), .PROTOTYPE_I(proto),
		.PROGRAMMABLE_I(progr), .SOFTSTART_DONE_I(ss), .SELFTEST_FAIL_I(st_fail),
		.FW_CSUM_FAIL_I(csum), .FW_REPROG_I(reprog), .NVM_CHECK_DONE_I(nvm_done),
		.NVM_BAD_I(nvm_bad), .BOARD_ID_I(bid), .POWER_ID_I(pid), .PS_OVERTEMP_I(pt),
		.PS_OVERCURRENT_I(pc), .PS_SUPPLY_LOST_I(pl), .DRIVE_HOT_I(dhot),
		.MOTOR_HOT_I(mhot), .ENC_STATE_ERR_I(enc_st), .ENC_HW_ERR_I(enc_hw),
		.SHUNT_OVER_I(shunt), .OVERSPEED_I(ospd), .FOLLOW_ERR_I(fol), .LIMIT_POS_I(lp),
		.LIMIT_NEG_I(ln), .SYNC_ERR_I(sync), .RUNTIME_ERR_I(rt), .RESET_BUTTON_I(rbtn),
		.RESET_INPUT_I(rin), .ENC_A_I(enc_a), .ENC_B_I(enc_b), .STATUS_CODE_I(status),
		.DISPLAY_O(disp), .FAULT_SHOWN_O(shown), .BRIDGE_EN_O(bren),
		.ACTIVE_FAULTS_O(act), .POSITION_O(pos));
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	// Settled outputs lag an input change by two edges
	task automatic req_reset(input logic by_input);
		if (by_input) rin = 1'b1;
		else rbtn = 1'b1;
		tick(3);
		rin = 1'b0;
		rbtn = 1'b0;
	endtask
	task automatic power_cycle();
		arst_n = 1'b0;
		tick(16);
		arst_n = 1'b1;
		tick(2);
	endtask
	task automatic t_encoder();
		bus = 10'h1A0;
		dir = 1'b1;
		step = 1'b1;
		tick(10);
		dir = 1'b0;
		tick(3);
		step = 1'b0;
		tick(3);
		chk(bren, 1'b0, "bridge during fault");
		chk(pos, 32'h7, "position during fault");
		bus = 10'h12C;
		req_reset(1'b0);
		progr = 1'b0;
		enc_st = 1'b1;
		enc_hw = 1'b1;
		tick(1);
		enc_st = 1'b0;
		enc_hw = 1'b0;
		req_reset(1'b1);
		chk(act[F_ENC_HW:F_ENC_STATE], 2'h3, "encoder faults fixed variant");
		progr = 1'b1;
		req_reset(1'b1);
		chk(act[F_ENC_HW:F_ENC_STATE], 2'h0, "encoder faults programmable");
		enc_hw = 1'b1;
		tick(1);
		enc_hw = 1'b0;
		tick(2);
		chk(disp, F_ENC_HW + 1, "enc hw code");
		req_reset(1'b0);
		chk(act[F_ENC_HW], 1'b0, "enc hw programmable");
		progr = 1'b0;
		$display("Test encoder done");
	endtask
	task automatic t_bus();
		bus = 10'h19F;
		tick(3);
		chk(act[F_BUS_HIGH], 1'b0, "415 V no fault");
		bus = 10'h1A0;
		tick(3);
		chk(act[F_BUS_HIGH], 1'b1, "overvoltage");
		chk(disp, F_BUS_HIGH + 1, "overvoltage code");
		chk(shown, 1'b1, "fault shown");
		req_reset(1'b0);
		chk(act[F_BUS_HIGH], 1'b1, "reset refused");
		bus = 10'h12C;
		tick(3);
		chk(act[F_BUS_HIGH], 1'b1, "stays latched");
		req_reset(1'b1);
		chk(disp, status, "status back");
		chk(shown, 1'b0, "fault not shown");
		chk(bren, 1'b1, "bridge back");
		bus = 10'h03C;
		tick(DEB + 5);
		chk(act[F_BUS_LOW], 1'b0, "60 V no fault");
		bus = 10'h03B;
		tick(DEB - 5);
		bus = 10'h12C;
		tick(3);
		chk(act[F_BUS_LOW], 1'b0, "short dip");
		mon_en = 1'b0;
		bus = 10'h03B;
		tick(DEB + 5);
		chk(act[F_BUS_LOW], 1'b0, "monitor off");
		mon_en = 1'b1;
		tick(DEB + 5);
		chk(act[F_BUS_LOW], 1'b1, "undervoltage");
		bus = 10'h12C;
		req_reset(1'b0);
		chk(act[F_BUS_LOW], 1'b0, "undervoltage reset");
		proto = 1'b1;
		mon_en = 1'b0;
		bus = 10'h03B;
		tick(DEB + 3);
		chk(act[F_BUS_LOW], 1'b1, "prototype cannot disable");
		bus = 10'h08B;
		req_reset(1'b0);
		chk(act[F_BUS_LOW], 1'b1, "prototype below recovery");
		bus = 10'h08C;
		tick(3);
		chk(act[F_BUS_LOW], 1'b0, "prototype auto clear");
		bus = 10'h12C;
		ss = 1'b1;
		tick(1);
		ss = 1'b0;
		bus = 10'h0FA;
		tick(DEB + 3);
		chk(act[F_BUS_LOW], 1'b0, "drop of 50 V no fault");
		bus = 10'h0F9;
		tick(DEB + 3);
		chk(act[F_BUS_LOW], 1'b1, "drop below soft-start");
		bus = 10'h12C;
		tick(3);
		chk(act[F_BUS_LOW], 1'b0, "drop auto clear");
		proto = 1'b0;
		mon_en = 1'b1;
		$display("Test bus done");
	endtask
	task automatic t_misc();
		lp = 1'b1;
		tick(3);
		chk({act[F_LIMIT_POS], bren}, 2'h3, "limit keeps bridge");
		lp = 1'b0;
		ln = 1'b1;
		tick(3);
		chk(act[F_LIMIT_POS], 1'b0, "limit auto clear");
		chk(disp, F_LIMIT_NEG + 1, "limit code");
		ln = 1'b0;
		for (int i = 0; i < 3; i++) begin
			{pt, pc, pl} = 3'h4 >> i;
			tick(3);
			chk(act[F_PWR_MOD], 1'b1, "power module");
			{pt, pc, pl} = 3'h0;
			req_reset(1'b0);
		end
		bid = 8'h5B;
		nvm_bad = 1'b1;
		nvm_done = 1'b1;
		tick(1);
		nvm_done = 1'b0;
		tick(2);
		chk(act[F_CONFIG:F_NVM], 2'h3, "config and memory");
		bid = 8'h5A;
		nvm_bad = 1'b0;
		mhot = 1'b1;
		dhot = 1'b1;
		tick(3);
		mhot = 1'b0;
		dhot = 1'b0;
		tick(3);
		chk(act[F_MOT_HOT:F_NVM], 9'h103, "cooling");
		req_reset(1'b1);
		chk(act, 18'h0, "all clear");
		{shunt, ospd, fol, rt} = 4'hF;
		tick(3);
		chk(disp, F_SHUNT + 1, "shunt code");
		chk(bren, 1'b0, "bridge off for run faults");
		{shunt, ospd, fol, rt} = 4'h0;
		req_reset(1'b0);
		chk({act[F_RUNTIME], act[F_FOLLOW:F_SHUNT]}, 4'h0, "run faults reset");
		csum = 1'b1;
		st_fail = 1'b1;
		tick(3);
		chk(disp, F_FLASH + 1, "flash first");
		csum = 1'b0;
		req_reset(1'b0);
		chk(act[F_FLASH], 1'b1, "flash holds");
		reprog = 1'b1;
		tick(3);
		reprog = 1'b0;
		chk(disp, F_SELFTEST + 1, "next priority");
		sync = 1'b1;
		tick(1);
		sync = 1'b0;
		st_fail = 1'b0;
		req_reset(1'b1);
		chk(act[F_SELFTEST], 1'b1, "selftest holds");
		chk(act[F_SYNC], 1'b1, "sync holds");
		power_cycle();
		chk(act, 18'h0, "power cycle clears");
		chk(pos, 32'h0, "no count after reset");
		$display("Test misc done");
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Whole run needs well under 1000 cycles
	initial begin
		#20000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		give_verdict();
	end
	initial begin
		tick(16);
		arst_n = 1'b1;
		tick(2);
		t_encoder();
		t_bus();
		t_misc();
		give_verdict();
	end
endmodule

// ==== tb/sfm_plant_model.sv ====
`timescale 1ns/1ps
// Quadrature encoder on the motor shaft, stepped by the bench
module sfm_plant_model (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic enc_a_o,
	output logic enc_b_o
);
	logic [1:0] ph_q = 2'h0;
	// Gray order, B leads A going forward; one line changes per step
	always @(posedge clk_i) begin
		if (step_i) begin
			ph_q <= dir_i ? ph_q + 2'h1 : ph_q - 2'h1;
		end
	end
	assign enc_a_o = ph_q[1];
	assign enc_b_o = ph_q[1] ^ ph_q[0];
endmodule
